// [rtl/ovn_regs.svh]
// Purpose: Offsets, field positions, reset values and limits of the oven controller
// Assumes: 40 MHz reference clock, word-aligned byte addresses
// Notes: Definitions only
`ifndef OVN_REGS_SVH
`define OVN_REGS_SVH
`define OVN_A_CTRL 8'h00
`define OVN_A_SETPT 8'h04
`define OVN_A_TIME 8'h08
`define OVN_A_SEG0 8'h0C
`define OVN_A_STAT 8'h24
`define OVN_A_CYC 8'h28
`define OVN_A_FCLO 8'h2C
`define OVN_A_FCHI 8'h30
`define OVN_C_SAVE 8
`define OVN_C_START 9
`define OVN_C_WARM 10
`define OVN_C_COOL 11
`define OVN_C_STOP 12
`define OVN_C_CLR 13
`define OVN_SETPT_RST 10'h15E
`define OVN_SETPT_MIN 10'h15E
`define OVN_SETPT_STEP 10'h019
`define OVN_SETPT_STEPS 8
`define OVN_TIME_MIN 9'h001
`define OVN_TIME_MAX_MIN 5
`define OVN_TIME_MAX 9'(`OVN_TIME_MAX_MIN * 60)
`define OVN_PCT_MAX 7'h64
`define OVN_AIR_MIN 7'h0A
`define OVN_TUBE_MIN_A 7
`define OVN_TUBE_MIN 8'(`OVN_TUBE_MIN_A * 10)
`define OVN_UNDERHEAT 10'h054
`define OVN_ELEC_MAX 8'h8C
`define OVN_HX_RISE 10'h00E
`define OVN_IDLE_AIR 7'h1E
`define OVN_CLK_HZ 40000000
`define OVN_CTICK_MS 10
`define OVN_CTICK_CYC (`OVN_CLK_HZ / 1000 * `OVN_CTICK_MS)
`define OVN_HX_WIN_S 30
`define OVN_HX_WIN_TK 12'(`OVN_HX_WIN_S * 1000 / `OVN_CTICK_MS)
`endif

// [rtl/ovn_pkg.sv]
// Purpose: Types of the oven controller
// Assumes: Nothing
// Notes: Fault index 0 is the highest priority
package ovn_pkg;
  typedef enum logic [2:0] {
    MODE_STBY = 3'b000,
    MODE_WARM = 3'b001,
    MODE_READY = 3'b010,
    MODE_COOK = 3'b011,
    MODE_COOL = 3'b100
  } ovn_mode_e;
  typedef struct packed {
    logic [6:0] mw;
    logic [6:0] air;
    logic [6:0] dur;
  } ovn_seg_s;
  typedef struct packed {
    logic [40:0] s1;
    logic [40:0] s2;
    ovn_mode_e mode;
    logic [2:0] seg;
    logic [31:0] tick;
    logic [15:0] elap;
    logic multi;
    logic [8:0] rtime;
    ovn_seg_s [5:0] rseg;
    logic [3:0] fcode;
    logic [7:0] fprev;
    logic [7:0][7:0] fcnt;
    logic [15:0] cycles;
    logic [9:0] setpt;
    logic [8:0] stime;
    ovn_seg_s [5:0] sseg;
    logic reject;
    logic [63:0] slot_ok;
    logic [9:0] hx_base;
    logic [11:0] hx_win;
    logic heat;
    logic [6:0] blow;
    logic [6:0] tube;
    logic [1:0] blow_on;
    logic [1:0] tube_on;
    logic fan;
    logic [31:0] rdata;
  } ovn_state_s;
endpackage

// [rtl/ovn_ctrl.sv]
// Purpose: Recipe sequencer, limit checks and fault ranking of a combination oven
// Assumes: Sensor inputs are asynchronous and pass two flip-flops
// Notes: Recipes are written through a staging area, then saved to a slot
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "ovn_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - A recipe holds up to six ordered segments with share, airflow, microwave.
// - Saving is refused unless the six segment shares sum to exactly 100.
// - Saving is refused unless total cook time lies within 1 to 300 s.
// - Used segment airflow must be 10 to 100; unused ones may be zero.
// - Each segment microwave level must lie within 0 to 100.
// - Setpoint accepts only 350 to 525 F in 25 F steps.
// - Sixty-four slots, addressed as group of eight then item of eight.
// - Faults ranked; highest is reported and terminating ones halt all modes but cool-down.
// - Each fault occurrence bumps its counter; clearing never lowers it.
// - Fault counters are eight bits and wrap from 255 to zero.
// - Completed cook cycle counter holds up to 65535 and stops there.
// - Cycle counted after segment one, or at end for single-segment recipes.
// - Tube current under 7 A while microwave is on is a fault.
// - Chamber more than 84 F under setpoint while cooking is a fault.
// - Tripped tube thermal cutout is a fault.
// - Missing blower run signal while airflow is commanded is a fault.
// - Electronics temperature above 140 F is a fault.
// - Electronics overheat alerts but does not stop a cook cycle.
// - Monitor switch disagreeing with primary and secondary switches is a fault.
// - Exchanger failing to rise 14 F within each 30 s warm-up window.
// - Cool-down keeps only cooling fan and blower running.
// - Door opened during a cook cycle is a fault.
module ovn_ctrl
  import ovn_pkg::*;
#(
  parameter int CTICK_CYCLES = `OVN_CTICK_CYC
) (
  input wire logic ref_clk_in, // 40 MHz
  input wire logic rst_n_in, // Synchronous reset
  input wire logic [7:0] addr_in, // Register byte address
  input wire logic [31:0] wdata_in, // Write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [31:0] rdata_out, // Read data, cycle after strobe
  input wire logic door_pri_in, // Primary switch closed
  input wire logic door_sec_in, // Secondary switch closed
  input wire logic door_mon_in, // Monitor switch closed
  input wire logic tube_trip_in, // Tube cutout tripped
  input wire logic blower_run_in, // Blower run status
  input wire logic [7:0] tube_amps_in, // Tube current, 0.1 A
  input wire logic [9:0] chamber_temp_in, // Chamber, deg F
  input wire logic [9:0] exchanger_temperature_in, // Exchanger, deg F
  input wire logic [7:0] elec_temp_in, // Electronics, deg F
  output logic heater_on_out, // Heater load
  output logic [6:0] blower_level_out, // Airflow percent
  output logic [6:0] microwave_level_out, // Microwave percent
  output logic cool_fan_out, // Cooling fan load
  output logic cooking_out, // Cook cycle active
  output logic [3:0] fault_code_out, // Reported fault, 0 none
  output logic alert_out // Electronics overheat alert
);
  ovn_state_s st_q;
  ovn_state_s st_d;
  logic [7:0] det;
  logic [7:0] newf;
  logic [7:0] stop_mask;
  logic [9:0] dur_sum;
  logic rec_bad;
  logic save_cmd;
  logic p_cl;
  logic s_cl;
  logic m_cl;
  logic trip;
  logic brun;
  logic [7:0] amps;
  logic [9:0] cc_t;
  logic [9:0] hx_t;
  logic [7:0] ec_t;
  logic tk;
  logic [15:0] seg_len;
  logic seg_end;
  logic [9:0] setpt_lo;

  assign {p_cl, s_cl, m_cl, trip, brun, amps, cc_t, hx_t, ec_t} = st_q.s2;
  assign stop_mask = 8'hDF;
  assign setpt_lo = (st_q.setpt > `OVN_UNDERHEAT) ? st_q.setpt - `OVN_UNDERHEAT : 10'h000;
  assign tk = (st_q.tick == 32'(CTICK_CYCLES - 1));
  assign seg_len = 16'(st_q.rtime * st_q.rseg[st_q.seg].dur);
  assign seg_end = (st_q.mode == MODE_COOK) && (st_q.elap >= seg_len);
  assign save_cmd = wr_in && addr_in == `OVN_A_CTRL && wdata_in[`OVN_C_SAVE];

  ////////////////////////////////////////////////////////////////////////////
  // Recipe checks on the staging area
  always_comb
  begin
    dur_sum = 10'h000;
    rec_bad = (st_q.stime < `OVN_TIME_MIN) || (st_q.stime > `OVN_TIME_MAX);
    for (int i = 0; i < 6; i++)
    begin
      dur_sum = dur_sum + 10'(st_q.sseg[i].dur);
      if (st_q.sseg[i].mw > `OVN_PCT_MAX)
        rec_bad = 1'b1;
      if (st_q.sseg[i].air > `OVN_PCT_MAX)
        rec_bad = 1'b1;
      if (st_q.sseg[i].air < `OVN_AIR_MIN && !(st_q.sseg[i].dur == 7'h00
          && st_q.sseg[i].air == 7'h00))
        rec_bad = 1'b1;
    end
    if (dur_sum != 10'(`OVN_PCT_MAX))
      rec_bad = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault conditions, index 0 ranks highest
  always_comb
  begin
    det = 8'h00;
    // Run status and current lag the load by the synchroniser; wait it out
    det[0] = (st_q.blow != 7'h00) && st_q.blow_on[1] && !brun;
    det[1] = (st_q.mode == MODE_COOK) && (cc_t < setpt_lo);
    det[2] = (st_q.tube != 7'h00) && st_q.tube_on[1] && (amps < `OVN_TUBE_MIN);
    det[3] = m_cl != (p_cl && s_cl);
    det[4] = trip;
    det[5] = ec_t > `OVN_ELEC_MAX;
    det[6] = (st_q.mode == MODE_WARM) && tk && (st_q.hx_win == `OVN_HX_WIN_TK - 12'h001)
      && (hx_t < st_q.hx_base + `OVN_HX_RISE);
    det[7] = (st_q.mode == MODE_COOK) && !(p_cl && s_cl);
    newf = det & ~st_q.fprev;
  end

  // Recipe slots, group in bits 5:3 and item in 2:0
  ovn_seg_s [5:0] mem_seg [64];
  logic [8:0] mem_time [64];
  always_ff @(posedge ref_clk_in)
  begin
    if (save_cmd && !rec_bad)
    begin
      mem_seg[wdata_in[5:0]] <= st_q.sseg;
      mem_time[wdata_in[5:0]] <= st_q.stime;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic hit;
    logic [5:0] slot;
    logic [3:0] best;
    hit = 1'b0;
    slot = wdata_in[5:0];
    best = 4'h0;
    st_d = st_q;
    st_d.rdata = 32'h0000_0000;
    st_d.s1 = {door_pri_in, door_sec_in, door_mon_in, tube_trip_in, blower_run_in,
      tube_amps_in, chamber_temp_in, exchanger_temperature_in, elec_temp_in};
    st_d.s2 = st_q.s1;
    st_d.tick = tk ? 32'h0000_0000 : st_q.tick + 32'h0000_0001;
    st_d.fprev = det;
    st_d.blow_on = {st_q.blow_on[0], st_q.blow != 7'h00};
    st_d.tube_on = {st_q.tube_on[0], st_q.tube != 7'h00};
    for (int i = 0; i < 8; i++)
      if (newf[i])
        st_d.fcnt[i] = st_q.fcnt[i] + 8'h01;

    if (wr_in)
    begin
      unique case (addr_in)
        `OVN_A_CTRL:
        begin
          if (wdata_in[`OVN_C_CLR])
          begin
            st_d.fcode = 4'h0;
            st_d.reject = 1'b0;
          end
          if (wdata_in[`OVN_C_SAVE])
          begin
            if (rec_bad)
              st_d.reject = 1'b1;
            else
              st_d.slot_ok[slot] = 1'b1;
          end
          if (wdata_in[`OVN_C_WARM] && st_q.mode == MODE_STBY)
          begin
            st_d.mode = MODE_WARM;
            st_d.hx_base = hx_t;
            st_d.hx_win = 12'h000;
          end
          if (wdata_in[`OVN_C_START] && st_q.mode == MODE_READY && st_q.slot_ok[slot])
          begin
            st_d.mode = MODE_COOK;
            st_d.seg = 3'h0;
            st_d.elap = 16'h0000;
            st_d.rtime = mem_time[slot];
            st_d.rseg = mem_seg[slot];
            st_d.multi = |{mem_seg[slot][5].dur, mem_seg[slot][4].dur,
              mem_seg[slot][3].dur, mem_seg[slot][2].dur, mem_seg[slot][1].dur};
          end
          if (wdata_in[`OVN_C_COOL])
            st_d.mode = MODE_COOL;
          if (wdata_in[`OVN_C_STOP])
            st_d.mode = MODE_STBY;
        end
        `OVN_A_SETPT:
          for (int k = 0; k < `OVN_SETPT_STEPS; k++)
            if (wdata_in[9:0] == `OVN_SETPT_MIN + 10'(k) * `OVN_SETPT_STEP
                && wdata_in[31:10] == 22'h000000)
              st_d.setpt = wdata_in[9:0];
        `OVN_A_TIME:
          st_d.stime = wdata_in[8:0];
        default:
          for (int i = 0; i < 6; i++)
            if (addr_in == `OVN_A_SEG0 + 8'(4 * i))
              st_d.sseg[i] = {wdata_in[22:16], wdata_in[14:8], wdata_in[6:0]};
      endcase
    end

    if (st_q.mode == MODE_WARM)
    begin
      if (tk)
      begin
        st_d.hx_win = st_q.hx_win + 12'h001;
        if (st_q.hx_win == `OVN_HX_WIN_TK - 12'h001)
        begin
          st_d.hx_win = 12'h000;
          st_d.hx_base = hx_t;
        end
      end
      if (cc_t >= st_q.setpt && st_d.mode == MODE_WARM)
        st_d.mode = MODE_READY;
    end

    if (st_q.mode == MODE_COOK && st_d.mode == MODE_COOK)
    begin
      if (tk)
        st_d.elap = st_q.elap + 16'h0001;
      if (seg_end)
      begin
        st_d.elap = 16'h0000;
        if ((st_q.seg == 3'h0 && st_q.multi) || (st_q.seg == 3'h5 && !st_q.multi))
          if (st_q.cycles != 16'hFFFF)
            st_d.cycles = st_q.cycles + 16'h0001;
        if (st_q.seg == 3'h5)
          st_d.mode = MODE_READY;
        else
          st_d.seg = st_q.seg + 3'h1;
      end
    end

    // Ranking runs after the clear so a fault in the same cycle survives it
    for (int i = 7; i >= 0; i--)
      if (det[i])
      begin
        hit = 1'b1;
        best = 4'(i + 1);
      end
    if (hit && (st_d.fcode == 4'h0 || best < st_d.fcode))
      st_d.fcode = best;
    if (|(det & stop_mask) && st_q.mode != MODE_STBY && st_q.mode != MODE_COOL)
      st_d.mode = MODE_STBY;

    st_d.heat = 1'b0;
    st_d.blow = 7'h00;
    st_d.tube = 7'h00;
    st_d.fan = 1'b0;
    unique case (st_d.mode)
      MODE_STBY: ;
      MODE_WARM, MODE_READY:
      begin
        st_d.heat = cc_t < st_q.setpt;
        st_d.blow = `OVN_IDLE_AIR;
        st_d.fan = 1'b1;
      end
      MODE_COOK:
      begin
        st_d.heat = cc_t < st_q.setpt;
        st_d.blow = st_d.rseg[st_d.seg].air;
        st_d.tube = st_d.rseg[st_d.seg].mw;
        st_d.fan = 1'b1;
      end
      MODE_COOL:
      begin
        st_d.blow = `OVN_IDLE_AIR;
        st_d.fan = 1'b1;
      end
      default: ;
    endcase

    if (rd_in)
    begin
      unique case (addr_in)
        `OVN_A_SETPT: st_d.rdata = {22'h000000, st_q.setpt};
        `OVN_A_TIME: st_d.rdata = {23'h000000, st_q.stime};
        `OVN_A_STAT:
          st_d.rdata = {16'h0000, st_q.reject, 4'h0, st_q.fcode, st_q.seg,
            1'b0, st_q.mode};
        `OVN_A_CYC: st_d.rdata = {16'h0000, st_q.cycles};
        `OVN_A_FCLO: st_d.rdata = st_q.fcnt[3:0];
        `OVN_A_FCHI: st_d.rdata = st_q.fcnt[7:4];
        default:
          for (int i = 0; i < 6; i++)
            if (addr_in == `OVN_A_SEG0 + 8'(4 * i))
              st_d.rdata = {9'h000, st_q.sseg[i].mw, 1'b0, st_q.sseg[i].air,
                1'b0, st_q.sseg[i].dur};
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      st_q <= '0;
      st_q.mode <= MODE_STBY;
      st_q.setpt <= `OVN_SETPT_RST;
    end
    else
      st_q <= st_d;
  end

  assign rdata_out = st_q.rdata;
  assign heater_on_out = st_q.heat;
  assign blower_level_out = st_q.blow;
  assign microwave_level_out = st_q.tube;
  assign cool_fan_out = st_q.fan;
  assign cooking_out = st_q.mode == MODE_COOK;
  assign fault_code_out = st_q.fcode;
  assign alert_out = st_q.fprev[5];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  cool_loads_off_a: assert property (
    st_q.mode == MODE_COOL |-> !heater_on_out && microwave_level_out == 7'h00 && cool_fan_out)
    else $error("load active in cool-down");
  seg_index_max_a: assert property (st_q.seg <= 3'h5)
    else $error("segment index beyond six");
  setpt_grid_a: assert property (
    st_q.setpt >= 10'd350 && st_q.setpt <= 10'd525 && (st_q.setpt - 10'd350) % 25 == 0)
    else $error("setpoint off grid");
  fcnt_wrap_a: assert property (
    st_q.fcnt[4] == 8'hFF && newf[4] |=> st_q.fcnt[4] == 8'h00)
    else $error("fault counter did not wrap");
  fcnt_no_dec_a: assert property (
    1'b1 |=> st_q.fcnt[0] == $past(st_q.fcnt[0]) || st_q.fcnt[0] == $past(st_q.fcnt[0]) + 8'h01)
    else $error("fault counter moved wrongly");
  halt_on_fault_a: assert property (
    st_q.mode == MODE_COOK && |(det & 8'hDF) |=> st_q.mode == MODE_STBY
    ##0 !heater_on_out && microwave_level_out == 7'h00)
    else $error("terminating fault did not halt");
  elec_no_stop_a: assert property (
    st_q.mode == MODE_COOK && det == 8'h20 && !wr_in |=> st_q.mode != MODE_STBY)
    else $error("electronics alert stopped cook");
  bad_recipe_a: assert property (
    save_cmd && dur_sum != 10'd100 |=> st_q.reject && st_q.slot_ok == $past(st_q.slot_ok))
    else $error("bad recipe was stored");
  bad_time_a: assert property (
    save_cmd && st_q.stime > 9'd300 |=> st_q.reject)
    else $error("bad cook time accepted");
  low_current_a: assert property (
    st_q.tube != 7'h00 && $past(st_q.tube, 2) != 7'h00 && amps < 8'd70
    |=> fault_code_out != 4'h0 && fault_code_out <= 4'h3)
    else $error("low tube current not reported");
  cycle_once_a: assert property (
    st_q.mode == MODE_COOK && seg_end && st_q.seg == 3'h0 && !st_q.multi
    |=> st_q.cycles == $past(st_q.cycles))
    else $error("single segment counted early");

  cycle_done_c: cover property (st_q.mode == MODE_COOK ##1 st_q.mode == MODE_READY);
  fault_latch_c: cover property (fault_code_out == 4'h0 ##1 fault_code_out != 4'h0);
  save_ok_c: cover property (save_cmd && !rec_bad);
  cool_down_c: cover property (st_q.mode == MODE_COOL);
endmodule // ovn_ctrl

// [dv/ovn_load_model.sv]
// Purpose: Oven loads and sensors behind the controller
// Assumes: Chamber heats and cools slowly against the clock
// Notes: Knobs hide blower run, set tube current, upset the monitor switch
`timescale 1ns/10ps
module ovn_load_model (
  input wire logic clk_in, // Bench clock
  input wire logic heater_in, // Heater load
  input wire logic [6:0] blower_in, // Airflow command
  input wire logic [6:0] mw_in, // Microwave command
  input wire logic blower_bad_in, // Hide run status
  input wire logic [7:0] amps_in, // Current while tube on
  input wire logic mon_bad_in, // Monitor out of step
  output logic run_out, // Blower run status
  output logic [7:0] amps_out, // Tube current
  output logic [9:0] chamber_out, // Chamber temperature
  output logic [9:0] exch_out, // Exchanger temperature
  output logic pri_out, // Primary switch
  output logic sec_out, // Secondary switch
  output logic mon_out // Monitor switch
);
  logic [5:0] div_q = 6'h00;
  logic [9:0] temp_q = 10'h046;
  // Heats sixteen times faster than it cools, so cooking holds setpoint
  always @(posedge clk_in)
  begin
    div_q <= div_q + 6'h01;
    if (heater_in && div_q[1:0] == 2'h0)
      temp_q <= temp_q + 10'h001;
    else if (!heater_in && div_q == 6'h00 && temp_q > 10'h046)
      temp_q <= temp_q - 10'h001;
  end
  assign chamber_out = temp_q;
  assign exch_out = temp_q + 10'h032;
  assign run_out = (blower_in != 7'h00) && !blower_bad_in;
  assign amps_out = (mw_in != 7'h00) ? amps_in : 8'h00;
  assign pri_out = 1'b1;
  assign sec_out = 1'b1;
  assign mon_out = !mon_bad_in;
endmodule // ovn_load_model

// [dv/ovn_tb.sv]
// Purpose: Self-checking bench of the oven controller
// Assumes: Tick shortened to four clocks
// Notes: Recipe checks mix fixed corners with seeded random recipes
`timescale 1ns/10ps
`include "ovn_regs.svh"
module testbench;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic tube_trip_in = 1'b0;
  logic [7:0] elec_temp_in = 8'h64;
  logic blower_bad = 1'b0;
  logic [7:0] amps = 8'h5A;
  logic mon_bad = 1'b0;
  wire logic [31:0] rdata_out;
  wire logic door_pri_in, door_sec_in, door_mon_in, blower_run_in;
  wire logic [7:0] tube_amps_in;
  wire logic [9:0] chamber_temp_in, exchanger_temperature_in;
  wire logic heater_on_out, cool_fan_out, cooking_out, alert_out;
  wire logic [6:0] blower_level_out, microwave_level_out;
  wire logic [3:0] fault_code_out;
  int mismatches = 0;
  int comparisons = 0;
  int seed = 32'h5FFC;
  int n;
  int v;
  int exp_sp = 32'h15E;
  logic [31:0] d;
  logic [8:0] rtime;
  logic [6:0] dur [6];
  logic [6:0] air [6];
  logic [6:0] mwl [6];

  always #12.5 ref_clk_in = ~ref_clk_in;

  ovn_ctrl #(.CTICK_CYCLES(4)) ovn_ctrl_inst (
    .ref_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .door_pri_in, .door_sec_in, .door_mon_in, .tube_trip_in, .blower_run_in,
    .tube_amps_in, .chamber_temp_in, .exchanger_temperature_in, .elec_temp_in,
    .heater_on_out, .blower_level_out, .microwave_level_out, .cool_fan_out,
    .cooking_out, .fault_code_out, .alert_out
  );
  ovn_load_model ovn_load_model_inst (
    .clk_in(ref_clk_in), .heater_in(heater_on_out), .blower_in(blower_level_out),
    .mw_in(microwave_level_out), .blower_bad_in(blower_bad), .amps_in(amps),
    .mon_bad_in(mon_bad), .run_out(blower_run_in), .amps_out(tube_amps_in),
    .chamber_out(chamber_temp_in), .exch_out(exchanger_temperature_in),
    .pri_out(door_pri_in), .sec_out(door_sec_in), .mon_out(door_mon_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic time_out();
    mismatches++;
    $display("BAD %0t wait ran out", $time);
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] w);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= w;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  task automatic wait_mode(input logic [2:0] m);
    rd_reg(`OVN_A_STAT);
    for (n = 0; n < 3000 && d[2:0] !== m; n++)
      rd_reg(`OVN_A_STAT);
    if (n == 3000)
      time_out();
  endtask
  task automatic wait_mw(input logic [6:0] m);
    for (n = 0; n < 400 && microwave_level_out !== m; n++)
      cyc(1);
    if (n == 400)
      time_out();
  endtask
  task automatic set_rec(input logic [8:0] t, input logic [6:0] d0, a0, m0, d1, a1, m1);
    rtime = t;
    for (int k = 0; k < 6; k++)
    begin
      dur[k] = 7'h00;
      air[k] = 7'h00;
      mwl[k] = 7'h00;
    end
    dur[0] = d0;
    air[0] = a0;
    mwl[0] = m0;
    dur[1] = d1;
    air[1] = a1;
    mwl[1] = m1;
  endtask
  task automatic load_rec();
    wr_reg(`OVN_A_TIME, {23'h0, rtime});
    for (int k = 0; k < 6; k++)
      wr_reg(8'(`OVN_A_SEG0 + 4 * k), {9'h0, mwl[k], 1'b0, air[k], 1'b0, dur[k]});
  endtask
  function automatic logic rec_ok();
    int s = 0;
    logic ok = 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      s += dur[k];
      if (mwl[k] > 7'h64 || air[k] > 7'h64)
        ok = 1'b0;
      if (air[k] < 7'h0A && !(air[k] == 7'h00 && dur[k] == 7'h00))
        ok = 1'b0;
    end
    return ok && s == 32'h64 && rtime >= 9'h001 && rtime <= 9'h12C;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd_reg(`OVN_A_SETPT);
    chk(d, 32'h15E);
    rd_reg(`OVN_A_CYC);
    chk(d, 32'h0);
    rd_reg(8'h3C);
    chk(d, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      v = (i < 10) ? 32'h145 + 32'h19 * i : 32'h146 + {$random(seed)} % 32'hA9;
      wr_reg(`OVN_A_SETPT, 32'(v));
      if (v >= 32'h15E && v <= 32'h20D && (v - 32'h15E) % 32'h19 == 0)
        exp_sp = v;
      rd_reg(`OVN_A_SETPT);
      chk(d, 32'(exp_sp));
    end
    wr_reg(`OVN_A_SETPT, 32'h15E);
    // Corner recipes first, then seeded random ones
    for (int i = 0; i < 24; i++)
    begin
      set_rec(9'h03C, 7'h28, 7'h32, 7'h46, 7'h3C, 7'h50, 7'h14);
      case (i)
        0: rtime = 9'h03C;
        1: dur[1] = 7'h3B;
        2: rtime = 9'h000;
        3: rtime = 9'h12D;
        4: rtime = 9'h12C;
        5: rtime = 9'h001;
        6: air[0] = 7'h09;
        7: air[1] = 7'h65;
        8: mwl[0] = 7'h65;
        9: mwl[1] = 7'h64;
        10: air[2] = 7'h0A;
        11: dur[5] = 7'h01;
        default:
        begin
          rtime = 9'({$random(seed)} % 310);
          dur[0] = 7'({$random(seed)} % 101);
          dur[1] = 7'h64 - dur[0] + 7'($random(seed) & 1);
          air[0] = 7'({$random(seed)} % 106);
          mwl[1] = 7'({$random(seed)} % 104);
        end
      endcase
      load_rec();
      wr_reg(`OVN_A_CTRL, 32'h2107);
      rd_reg(`OVN_A_STAT);
      chk(d[15], !rec_ok());
    end
    set_rec(9'h001, 7'h28, 7'h32, 7'h46, 7'h3C, 7'h50, 7'h14);
    load_rec();
    wr_reg(`OVN_A_CTRL, 32'h213F);
    set_rec(9'h001, 7'h64, 7'h28, 7'h0A, 7'h00, 7'h00, 7'h00);
    load_rec();
    wr_reg(`OVN_A_CTRL, 32'h2108);
    wr_reg(`OVN_A_CTRL, 32'h0400);
    wait_mode(3'h2);
    wr_reg(`OVN_A_CTRL, 32'h0209);
    rd_reg(`OVN_A_STAT);
    chk(d[2:0], 32'h2);
    wr_reg(`OVN_A_CTRL, 32'h023F);
    cyc(2);
    chk({cooking_out, blower_level_out, microwave_level_out}, {1'b1, 7'h32, 7'h46});
    rd_reg(`OVN_A_CYC);
    chk(d, 32'h0);
    wait_mw(7'h14);
    chk(n >= 145 && n <= 165, 32'h1);
    chk(blower_level_out, 32'h50);
    rd_reg(`OVN_A_CYC);
    chk(d, 32'h1);
    wait_mode(3'h2);
    chk({microwave_level_out, blower_level_out}, {7'h00, 7'h1E});
    wr_reg(`OVN_A_CTRL, 32'h0208);
    cyc(100);
    rd_reg(`OVN_A_CYC);
    chk(d, 32'h1);
    wait_mode(3'h2);
    rd_reg(`OVN_A_CYC);
    chk(d, 32'h2);
    @(posedge ref_clk_in);
    elec_temp_in <= 8'h8C;
    cyc(5);
    chk(alert_out, 32'h0);
    wr_reg(`OVN_A_CTRL, 32'h023F);
    elec_temp_in <= 8'h8D;
    amps <= 8'h46;
    cyc(6);
    chk({alert_out, cooking_out, fault_code_out}, {1'b1, 1'b1, 4'h6});
    @(posedge ref_clk_in);
    amps <= 8'h45;
    cyc(6);
    chk({fault_code_out, cooking_out, microwave_level_out}, {4'h3, 1'b0, 7'h00});
    @(posedge ref_clk_in);
    amps <= 8'h5A;
    elec_temp_in <= 8'h64;
    wr_reg(`OVN_A_CTRL, 32'h2400);
    wait_mode(3'h2);
    @(posedge ref_clk_in);
    tube_trip_in <= 1'b1;
    blower_bad <= 1'b1;
    cyc(6);
    chk({fault_code_out, heater_on_out, blower_level_out}, {4'h1, 1'b0, 7'h00});
    @(posedge ref_clk_in);
    tube_trip_in <= 1'b0;
    blower_bad <= 1'b0;
    cyc(4);
    wr_reg(`OVN_A_CTRL, 32'h2000);
    cyc(2);
    chk(fault_code_out, 32'h0);
    rd_reg(`OVN_A_FCLO);
    chk(d, 32'h00010001);
    rd_reg(`OVN_A_FCHI);
    chk(d, 32'h00000101);
    wr_reg(`OVN_A_CTRL, 32'h0800);
    cyc(3);
    chk({heater_on_out, microwave_level_out, blower_level_out, cool_fan_out},
        {1'b0, 7'h00, 7'h1E, 1'b1});
    wr_reg(`OVN_A_CTRL, 32'h1000);
    mon_bad <= 1'b1;
    cyc(5);
    chk(fault_code_out, 32'h4);
    @(posedge ref_clk_in);
    mon_bad <= 1'b0;
    // Counter of fault five stands at one; 255 more wrap it
    repeat (255)
    begin
      @(posedge ref_clk_in);
      tube_trip_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      tube_trip_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
    end
    cyc(3);
    rd_reg(`OVN_A_FCHI);
    chk(d[7:0], 32'h0);
    wrap_up();
  end
endmodule // testbench
